/* File: rtl/alm_top.v */
// ambient light measurement control: conversion engine, i2c target, avalon registers
`timescale 1ns/1ps
`include "alm_defines.vh"

module alm_top #(
  parameter [31:0] CYC_PER_US = `ALM_CLK_MHZ,
  parameter [31:0] TMO_CYC    = `ALM_TMO_MS * `ALM_US_PER_MS * `ALM_CLK_MHZ,
  parameter [6:0]  I2C_ADDR   = `ALM_I2C_ADDR
) (
  clk,
  arst_n,
  avs_address,
  avs_read,
  avs_write,
  avs_writedata,
  avs_byteenable,
  avs_readdata,
  avs_waitrequest,
  light_code,
  scl_in,
  sda_in,
  sda_out,
  sda_oe,
  alert_irq
);
  input  wire        clk;
  input  wire        arst_n;
  input  wire [7:0]  avs_address;
  input  wire        avs_read;
  input  wire        avs_write;
  input  wire [31:0] avs_writedata;
  input  wire [3:0]  avs_byteenable;
  output reg  [31:0] avs_readdata;
  output wire        avs_waitrequest;
  input  wire [27:0] light_code;
  input  wire        scl_in;
  input  wire        sda_in;
  output wire        sda_out;
  output reg         sda_oe;
  output wire        alert_irq;

  localparam [1:0] C_IDLE = 2'b00;
  localparam [1:0] C_ARST = 2'b01;
  localparam [1:0] C_CONV = 2'b10;

  localparam [2:0] I_IDLE = 3'b000;
  localparam [2:0] I_ADDR = 3'b001;
  localparam [2:0] I_ACKA = 3'b010;
  localparam [2:0] I_PTR  = 3'b011;
  localparam [2:0] I_WDAT = 3'b100;
  localparam [2:0] I_ACKW = 3'b101;
  localparam [2:0] I_RDAT = 3'b110;
  localparam [2:0] I_RACK = 3'b111;

  // ---------------------------------------------------------------
  // reset release
  // ---------------------------------------------------------------
  reg rst_s1_reg;
  reg rst_n_reg;
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_s1_reg <= 1'b0;
      rst_n_reg  <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_n_reg  <= rst_s1_reg;
    end
  end

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  reg  [31:0] cfg_reg;
  reg  [31:0] result_reg;
  reg  [31:0] thr_lo_reg;
  reg  [31:0] thr_hi_reg;
  reg  [`ALM_ST_W-1:0] status_reg;
  reg  [`ALM_ST_W-1:0] mask_reg;
  reg  [`ALM_ST_W-1:0] st_set;
  reg  [`ALM_ST_W-1:0] cmp_set;
  reg         res_new_reg;
  reg  [27:0] shr_c;
  reg  [1:0]  cst_reg;
  reg         trig_reg;
  reg         ack_reg;
  reg         iw_pend_reg;
  reg  [7:0]  iw_ptr_reg;
  reg  [7:0]  iw_byte_reg;
  reg         tstart;
  reg         tarst;
  reg  [3:0]  exp_c;
  reg  [19:0] mant_c;
  reg         wr_en;
  reg  [5:0]  wr_idx;
  reg  [31:0] wr_data;
  reg  [3:0]  wr_be;
  reg  [1:0]  scl_sync_reg;
  reg  [1:0]  sda_sync_reg;
  reg         scl_d_reg;
  reg         sda_d_reg;
  reg  [31:0] tmo_cnt_reg;
  reg         tmo_hit;
  reg  [2:0]  ist_reg;
  reg  [2:0]  bit_reg;
  reg  [7:0]  sh_reg;
  reg  [7:0]  tx_reg;
  reg  [7:0]  ptr_reg;
  reg         rw_reg;
  reg         bdone_reg;
  reg         nack_reg;
  reg         iw_stb;
  integer     i;
  wire        tdone;
  wire [27:0] lin_c;
  wire [1:0]  mode;
  wire        wr_cfg;
  wire        av_req;
  wire        av_wr_go;
  wire        scl_rise;
  wire        scl_fall;
  wire        i2c_start;
  wire        i2c_stop;
  wire [31:0] rd_word_i2c;
  wire [7:0]  rd_byte;

  assign mode = cfg_reg[`ALM_CFG_MODE];

  // ---------------------------------------------------------------
  // register read and byte merge
  // ---------------------------------------------------------------
  function [31:0] rd_word;
    input [5:0] idx;
    begin
      case (idx)
        `ALM_OFF_CONFIG: rd_word = cfg_reg;
        `ALM_OFF_RESULT: rd_word = result_reg;
        `ALM_OFF_THR_LO: rd_word = thr_lo_reg;
        `ALM_OFF_THR_HI: rd_word = thr_hi_reg;
        `ALM_OFF_STATUS: rd_word = {28'h0000000, status_reg};
        `ALM_OFF_MASK:   rd_word = {28'h0000000, mask_reg};
        default:         rd_word = 32'h0000_0000;
      endcase
    end
  endfunction

  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  be;
    integer k;
    begin
      merge = old;
      for (k = 0; k < 4; k = k + 1) begin
        if (be[k]) begin
          merge[k*8 +: 8] = nw[k*8 +: 8];
        end
      end
    end
  endfunction

  // ---------------------------------------------------------------
  // avalon slave: one wait state on every access
  // ---------------------------------------------------------------
  assign av_req          = avs_read | avs_write;
  assign av_wr_go        = avs_write & ack_reg;
  assign avs_waitrequest = ~ack_reg;

  always @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      ack_reg      <= 1'b0;
      avs_readdata <= 32'h0000_0000;
    end else begin
      ack_reg <= av_req & ~ack_reg;
      if (avs_read && !ack_reg) begin
        avs_readdata <= rd_word(avs_address[7:2]);
      end
    end
  end

  // avalon wins a collision; a serial byte simply waits one cycle
  always @* begin
    wr_en   = 1'b0;
    wr_idx  = avs_address[7:2];
    wr_data = avs_writedata;
    wr_be   = avs_byteenable;
    if (av_wr_go) begin
      wr_en = 1'b1;
    end else if (iw_pend_reg) begin
      wr_en   = 1'b1;
      wr_idx  = iw_ptr_reg[7:2];
      wr_data = {4{iw_byte_reg}};
      wr_be   = 4'h1 << iw_ptr_reg[1:0];
    end
  end

  assign wr_cfg = wr_en && (wr_idx == `ALM_OFF_CONFIG);

  // ---------------------------------------------------------------
  // range selection and threshold code
  // ---------------------------------------------------------------
  always @* begin
    exp_c = cfg_reg[`ALM_CFG_RANGE];
    if (cfg_reg[`ALM_CFG_RANGE] > `ALM_RANGE_TOP) begin
      // auto: smallest range whose mantissa does not overflow
      exp_c = `ALM_RANGE_TOP;
      for (i = 8; i >= 0; i = i - 1) begin
        if ((light_code >> i) <= {8'h00, `ALM_MANT_MAX}) begin
          exp_c = i[3:0];
        end
      end
    end
    shr_c = light_code >> exp_c;
    if (shr_c > {8'h00, `ALM_MANT_MAX}) begin
      mant_c = `ALM_MANT_MAX;
    end else begin
      mant_c = shr_c[19:0];
    end
  end

  assign lin_c = {8'h00, result_reg[`ALM_RES_MANT]} << result_reg[`ALM_RES_EXP];

  // ---------------------------------------------------------------
  // conversion engine and registers
  // ---------------------------------------------------------------
  always @* begin
    tstart = 1'b0;
    tarst  = 1'b0;
    case (cst_reg)
      C_IDLE: begin
        // shutdown starts nothing
        if (trig_reg || mode == `ALM_MODE_CONT) begin
          tstart = 1'b1;
          tarst  = (mode == `ALM_MODE_FORCE);
        end
      end
      C_ARST: tstart = tdone;
      default: tstart = 1'b0;
    endcase
  end

  alm_conv_timer #(
    .CYC_PER_US (CYC_PER_US)
  ) u_timer (
    .clk        (clk),
    .rst_n      (rst_n_reg),
    .start      (tstart),
    .arst_phase (tarst),
    .ct         (cfg_reg[`ALM_CFG_CT]),
    .busy       (),
    .done       (tdone)
  );

  always @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      cfg_reg     <= `ALM_CFG_RST;
      result_reg  <= 32'h0000_0000;
      thr_lo_reg  <= `ALM_THR_LO_RST;
      thr_hi_reg  <= `ALM_THR_HI_RST;
      status_reg  <= {`ALM_ST_W{1'b0}};
      mask_reg    <= `ALM_MASK_RST;
      cst_reg     <= C_IDLE;
      trig_reg    <= 1'b0;
      iw_pend_reg <= 1'b0;
      iw_ptr_reg  <= 8'h00;
      iw_byte_reg <= 8'h00;
    end else begin
      if (iw_stb) begin
        iw_pend_reg <= 1'b1;
        iw_ptr_reg  <= ptr_reg;
        iw_byte_reg <= sh_reg;
      end else if (!av_wr_go) begin
        iw_pend_reg <= 1'b0;
      end
      case (cst_reg)
        C_IDLE: begin
          if (tstart) begin
            trig_reg <= 1'b0;
            cst_reg  <= tarst ? C_ARST : C_CONV;
          end
        end
        C_ARST: begin
          if (mode == `ALM_MODE_OFF) begin
            cst_reg <= C_IDLE;
          end else if (tdone) begin
            cst_reg <= C_CONV;
          end
        end
        C_CONV: begin
          if (mode == `ALM_MODE_OFF) begin
            cst_reg <= C_IDLE;
          end else if (tdone) begin
            cst_reg <= C_IDLE;
            result_reg[`ALM_RES_EXP]  <= exp_c;
            result_reg[`ALM_RES_MANT] <= mant_c;
            result_reg[`ALM_RES_CNT]  <= result_reg[`ALM_RES_CNT] + 4'h1;
            if (mode != `ALM_MODE_CONT && !wr_cfg) begin
              cfg_reg[`ALM_CFG_MODE] <= `ALM_MODE_OFF;
            end
          end
        end
        default: cst_reg <= C_IDLE;
      endcase
      if (wr_en) begin
        case (wr_idx)
          `ALM_OFF_CONFIG: begin
            cfg_reg <= merge(cfg_reg, wr_data, wr_be) & `ALM_CFG_MASK;
            if (wr_be[1] && (wr_data[`ALM_CFG_MODE] == `ALM_MODE_FORCE ||
                wr_data[`ALM_CFG_MODE] == `ALM_MODE_ONCE)) begin
              trig_reg <= 1'b1;
            end
          end
          `ALM_OFF_THR_LO: thr_lo_reg <= merge(thr_lo_reg, wr_data, wr_be) & `ALM_THR_MASK;
          `ALM_OFF_THR_HI: thr_hi_reg <= merge(thr_hi_reg, wr_data, wr_be) & `ALM_THR_MASK;
          `ALM_OFF_MASK: begin
            if (wr_be[0]) begin
              mask_reg <= wr_data[`ALM_ST_W-1:0];
            end
          end
          default: ;
        endcase
      end
      // set wins over a write-one clear in the same cycle
      if (wr_en && wr_idx == `ALM_OFF_STATUS && wr_be[0]) begin
        status_reg <= (status_reg & ~wr_data[`ALM_ST_W-1:0]) | st_set | cmp_set;
      end else begin
        status_reg <= status_reg | st_set | cmp_set;
      end
    end
  end

  // compare the freshly stored result once, on the cycle after it lands
  always @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      res_new_reg <= 1'b0;
    end else begin
      res_new_reg <= (cst_reg == C_CONV) && tdone && (mode != `ALM_MODE_OFF);
    end
  end

  always @* begin
    cmp_set = {`ALM_ST_W{1'b0}};
    if (res_new_reg) begin
      cmp_set[`ALM_ST_LOW]  = ({4'h0, lin_c} < thr_lo_reg);
      cmp_set[`ALM_ST_HIGH] = ({4'h0, lin_c} > thr_hi_reg);
    end
  end

  // one-cycle event pulses feeding the sticky status bits
  always @* begin
    st_set               = {`ALM_ST_W{1'b0}};
    st_set[`ALM_ST_TMO]  = tmo_hit;
    st_set[`ALM_ST_DONE] = (cst_reg == C_CONV) && tdone && (mode != `ALM_MODE_OFF);
  end

  assign alert_irq = |(status_reg & mask_reg);

  // ---------------------------------------------------------------
  // serial pin capture and bus timeout
  // ---------------------------------------------------------------
  always @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      scl_sync_reg <= 2'b11;
      sda_sync_reg <= 2'b11;
      scl_d_reg    <= 1'b1;
      sda_d_reg    <= 1'b1;
      tmo_cnt_reg  <= 32'h0000_0000;
      tmo_hit      <= 1'b0;
    end else begin
      scl_sync_reg <= {scl_sync_reg[0], scl_in};
      sda_sync_reg <= {sda_sync_reg[0], sda_in};
      scl_d_reg    <= scl_sync_reg[1];
      sda_d_reg    <= sda_sync_reg[1];
      tmo_hit      <= 1'b0;
      // counter holds at the top so the timeout fires once per low spell
      if (scl_sync_reg[1]) begin
        tmo_cnt_reg <= 32'h0000_0000;
      end else if (tmo_cnt_reg != TMO_CYC) begin
        tmo_cnt_reg <= tmo_cnt_reg + 32'h0000_0001;
        tmo_hit     <= (tmo_cnt_reg == TMO_CYC - 32'h0000_0001);
      end
    end
  end

  assign scl_rise    = scl_sync_reg[1] & ~scl_d_reg;
  assign scl_fall    = ~scl_sync_reg[1] & scl_d_reg;
  assign i2c_start   = scl_sync_reg[1] & scl_d_reg & sda_d_reg & ~sda_sync_reg[1];
  assign i2c_stop    = scl_sync_reg[1] & scl_d_reg & ~sda_d_reg & sda_sync_reg[1];
  assign rd_word_i2c = rd_word(ptr_reg[7:2]);
  assign rd_byte     = rd_word_i2c[ptr_reg[1:0]*8 +: 8];
  assign sda_out     = 1'b0;

  // ---------------------------------------------------------------
  // i2c target, alive in every operating mode
  // ---------------------------------------------------------------
  always @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      ist_reg   <= I_IDLE;
      bit_reg   <= 3'h0;
      sh_reg    <= 8'h00;
      tx_reg    <= 8'h00;
      ptr_reg   <= 8'h00;
      rw_reg    <= 1'b0;
      bdone_reg <= 1'b0;
      nack_reg  <= 1'b0;
      sda_oe    <= 1'b0;
      iw_stb    <= 1'b0;
    end else begin
      iw_stb <= 1'b0;
      if (tmo_hit || i2c_stop) begin
        ist_reg <= I_IDLE;
        sda_oe  <= 1'b0;
      end else if (i2c_start) begin
        ist_reg   <= I_ADDR;
        bit_reg   <= 3'h0;
        bdone_reg <= 1'b0;
        sda_oe    <= 1'b0;
      end else if (scl_rise) begin
        if (ist_reg == I_RACK) begin
          nack_reg <= sda_sync_reg[1];
        end else if (ist_reg == I_RDAT) begin
          bit_reg   <= bit_reg + 3'h1;
          bdone_reg <= (bit_reg == 3'h7);
        end else if (ist_reg == I_ADDR || ist_reg == I_PTR || ist_reg == I_WDAT) begin
          sh_reg    <= {sh_reg[6:0], sda_sync_reg[1]};
          bit_reg   <= bit_reg + 3'h1;
          bdone_reg <= (bit_reg == 3'h7);
        end
      end else if (scl_fall) begin
        case (ist_reg)
          I_ADDR: begin
            if (bdone_reg) begin
              bdone_reg <= 1'b0;
              if (sh_reg[7:1] == I2C_ADDR) begin
                rw_reg  <= sh_reg[0];
                sda_oe  <= 1'b1;
                ist_reg <= I_ACKA;
              end else begin
                ist_reg <= I_IDLE;
              end
            end
          end
          I_PTR, I_WDAT: begin
            if (bdone_reg) begin
              bdone_reg <= 1'b0;
              sda_oe    <= 1'b1;
              ist_reg   <= I_ACKW;
              if (ist_reg == I_PTR) begin
                ptr_reg <= sh_reg;
              end else begin
                iw_stb <= 1'b1;
              end
            end
          end
          I_ACKW: begin
            sda_oe  <= 1'b0;
            ist_reg <= I_WDAT;
          end
          I_ACKA: begin
            if (rw_reg) begin
              tx_reg  <= rd_byte;
              sda_oe  <= ~rd_byte[7];
              ist_reg <= I_RDAT;
            end else begin
              sda_oe  <= 1'b0;
              ist_reg <= I_PTR;
            end
          end
          I_RDAT: begin
            if (bdone_reg) begin
              bdone_reg <= 1'b0;
              sda_oe    <= 1'b0;
              ptr_reg   <= ptr_reg + 8'h01;
              ist_reg   <= I_RACK;
            end else begin
              tx_reg <= {tx_reg[6:0], 1'b0};
              sda_oe <= ~tx_reg[6];
            end
          end
          I_RACK: begin
            if (nack_reg) begin
              ist_reg <= I_IDLE;
            end else begin
              tx_reg  <= rd_byte;
              sda_oe  <= ~rd_byte[7];
              ist_reg <= I_RDAT;
            end
          end
          default: sda_oe <= 1'b0;
        endcase
      end
    end
  end
endmodule // alm_top

/* File: rtl/alm_defines.vh */
// constants shared by the ambient light measurement control block
//
// Summary of operation
// - SCL low for 28 ms resets bus logic
// - conversion-time code 0xB selects 800 ms
// - range code 0xC selects automatic range
// - power-up default is automatic range
// - nine manual ranges selectable instead of automatic
// - twelve conversion times, 600 us to 800 ms
// - power-up in shutdown, no conversions
// - continuous or one-shot measurement modes
// - alert pin flags a new result
// - results compared against thresholds, reported on alert
// - results readable over serial bus, proportional codes
// - 4-bit exponent gives range used
// - mode 0 off, 1 forced one-shot, 3 continuous
// - bus still answers while powered down
`ifndef ALM_DEFINES_VH
`define ALM_DEFINES_VH

// ---------------------------------------------------------------
// register word indices (avalon address bits 7:2, pointer bits 7:2)
// ---------------------------------------------------------------
`define ALM_OFF_CONFIG   6'h00
`define ALM_OFF_RESULT   6'h01
`define ALM_OFF_THR_LO   6'h02
`define ALM_OFF_THR_HI   6'h03
`define ALM_OFF_STATUS   6'h04
`define ALM_OFF_MASK     6'h05

// ---------------------------------------------------------------
// fields and reset values
// ---------------------------------------------------------------
`define ALM_CFG_RANGE    3:0
`define ALM_CFG_CT       7:4
`define ALM_CFG_MODE     9:8
`define ALM_CFG_MASK     32'h0000_03FF
`define ALM_CFG_RST      32'h0000_00BC
`define ALM_RES_EXP      31:28
`define ALM_RES_CNT      27:24
`define ALM_RES_MANT     19:0
`define ALM_THR_MASK     32'h0FFF_FFFF
`define ALM_THR_LO_RST   32'h0000_0000
`define ALM_THR_HI_RST   32'h0FFF_FFFF
`define ALM_ST_DONE      0
`define ALM_ST_LOW       1
`define ALM_ST_HIGH      2
`define ALM_ST_TMO       3
`define ALM_ST_W         4
`define ALM_MASK_RST     4'h1
`define ALM_RANGE_AUTO   4'hC
`define ALM_RANGE_TOP    4'h8
`define ALM_MANT_MAX     20'hFFFFF
`define ALM_MODE_OFF     2'h0
`define ALM_MODE_FORCE   2'h1
`define ALM_MODE_ONCE    2'h2
`define ALM_MODE_CONT    2'h3

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define ALM_CLK_MHZ      100
`define ALM_US_PER_MS    1000
`define ALM_TMO_MS       28
`define ALM_ARST_US      500
`define ALM_CT_MAX       4'hB
`define ALM_CT0_US       32'd600
`define ALM_CT1_US       32'd1000
`define ALM_CT2_US       32'd1800
`define ALM_CT3_US       32'd3400
`define ALM_CT4_US       32'd6500
`define ALM_CT5_US       32'd12700
`define ALM_CT6_US       32'd25000
`define ALM_CT7_US       32'd50000
`define ALM_CT8_US       32'd100000
`define ALM_CT9_US       32'd200000
`define ALM_CT10_US      32'd400000
`define ALM_CT11_US      32'd800000
`define ALM_I2C_ADDR     7'h44

`endif

/* File: rtl/alm_conv_timer.v */
// conversion and auto-range recovery interval timer
`timescale 1ns/1ps
`include "alm_defines.vh"

module alm_conv_timer #(
  parameter [31:0] CYC_PER_US = `ALM_CLK_MHZ
) (
  clk,
  rst_n,
  start,
  arst_phase,
  ct,
  busy,
  done
);
  input  wire        clk;
  input  wire        rst_n;
  input  wire        start;
  input  wire        arst_phase;
  input  wire [3:0]  ct;
  output wire        busy;
  output reg         done;

  reg  [31:0] cnt_reg;
  wire [31:0] load_us;

  // ---------------------------------------------------------------
  // conversion time lookup
  // ---------------------------------------------------------------
  function [31:0] ct_us;
    input [3:0] c;
    begin
      case (c)
        4'h0:    ct_us = `ALM_CT0_US;
        4'h1:    ct_us = `ALM_CT1_US;
        4'h2:    ct_us = `ALM_CT2_US;
        4'h3:    ct_us = `ALM_CT3_US;
        4'h4:    ct_us = `ALM_CT4_US;
        4'h5:    ct_us = `ALM_CT5_US;
        4'h6:    ct_us = `ALM_CT6_US;
        4'h7:    ct_us = `ALM_CT7_US;
        4'h8:    ct_us = `ALM_CT8_US;
        4'h9:    ct_us = `ALM_CT9_US;
        4'hA:    ct_us = `ALM_CT10_US;
        4'hB:    ct_us = `ALM_CT11_US;
        // codes above the top clamp to the longest time
        default: ct_us = `ALM_CT11_US;
      endcase
    end
  endfunction

  assign load_us = arst_phase ? `ALM_ARST_US : ct_us(ct);
  assign busy    = (cnt_reg != 32'h0000_0000);

  // ---------------------------------------------------------------
  // down counter
  // ---------------------------------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= 32'h0000_0000;
      done    <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        cnt_reg <= load_us * CYC_PER_US;
      end else if (cnt_reg == 32'h0000_0001) begin
        cnt_reg <= 32'h0000_0000;
        done    <= 1'b1;
      end else if (busy) begin
        cnt_reg <= cnt_reg - 32'h0000_0001;
      end
    end
  end
endmodule // alm_conv_timer

/* File: verif/alm_top_monitor.sv */
// assertion checker watching the light measurement control top ports
`timescale 1ns/1ps
module alm_mon #(
  parameter [31:0] TMO_CYC = 32'd200
) (
  input wire clk,
  input wire arst_n,
  input wire avs_read,
  input wire avs_write,
  input wire avs_waitrequest,
  input wire scl_in,
  input wire sda_out,
  input wire sda_oe,
  input wire alert_irq
);
  logic [31:0] low_cnt_reg;
  logic        seen_wr_reg;
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      low_cnt_reg <= 32'h0;
      seen_wr_reg <= 1'b0;
    end else begin
      low_cnt_reg <= scl_in ? 32'h0 : low_cnt_reg + 32'h1;
      seen_wr_reg <= seen_wr_reg | avs_write;
    end
  end
  // -----------------------------------------
  // properties
  // -----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence s_req;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_ans;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence
  a_req_answer: assert property (s_req |=> s_ans)
    else $error("request not answered in one wait state");
  a_wait_cause: assert property (!avs_waitrequest |-> $past(avs_read || avs_write))
    else $error("waitrequest dropped without a request");
  a_no_early_alert: assert property (!seen_wr_reg |-> !alert_irq)
    else $error("alert before any configuration");
  a_ack_scl_low: assert property ($rose(sda_oe) |-> !scl_in)
    else $error("sda pulled while scl high");
  a_rel_scl_low: assert property ($fell(sda_oe) |-> !scl_in)
    else $error("sda released while scl high");
  a_oe_steady: assert property (scl_in && $past(scl_in) |-> $stable(sda_oe))
    else $error("sda changed during scl high");
  a_tmo_release: assert property (low_cnt_reg == TMO_CYC + 32'd8 |-> !sda_oe)
    else $error("sda held after scl low timeout");
  a_open_drain: assert property (sda_oe |-> !sda_out)
    else $error("sda driven high");
endmodule // alm_mon

bind alm_top alm_mon #(.TMO_CYC(TMO_CYC)) u_mon (
  .clk(clk), .arst_n(arst_n), .avs_read(avs_read), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest), .scl_in(scl_in), .sda_out(sda_out),
  .sda_oe(sda_oe), .alert_irq(alert_irq));

/* File: verif/alm_i2c_ctl.sv */
// behavioural i2c bus controller facing the block's target port
`timescale 1ns/1ps
module alm_i2c_ctl (
  output logic scl,
  output logic sda_drv,
  input  wire  sda
);
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  task start;
    sda_drv = 1'b1;
    #40 scl = 1'b1;
    #40 sda_drv = 1'b0;
    #80 scl = 1'b0;
  endtask
  // low half wider so the synchronised target can turn sda round
  task bit_io(input logic d, output logic r);
    #20 sda_drv = d;
    #80 scl = 1'b1;
    #30 r = sda;
    #30 scl = 1'b0;
  endtask
  task xfer(input logic [7:0] d, input logic a, output logic [7:0] q, output logic r);
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(a, r);
  endtask
  task stop;
    #20 sda_drv = 1'b0;
    #80 scl = 1'b1;
    #40 sda_drv = 1'b1;
    #80;
  endtask
  // only a timeout scenario asks for this
  task stall(input int n);
    #(n * 10);
  endtask
endmodule // alm_i2c_ctl

/* File: verif/tb.sv */
// self-checking bench for the light measurement control block
`timescale 1ns/1ps
module tb;
  logic        clk;
  logic        arst_n;
  logic [7:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [27:0] light_code;
  logic        scl;
  logic        sda_drv;
  logic        sda_out;
  logic        sda_oe;
  logic        alert_irq;
  wire         sda = sda_oe ? 1'b0 : sda_drv;
  int          err_total;
  int          comparisons;
  int          n;
  logic [31:0] q;
  logic [7:0]  b;
  logic        r;

  alm_top #(.CYC_PER_US(32'd1), .TMO_CYC(32'd200)) dut (
    .clk(clk), .arst_n(arst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .light_code(light_code), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .alert_irq(alert_irq));
  alm_i2c_ctl ctl (.scl(scl), .sda_drv(sda_drv), .sda(sda));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task chk(input string s, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s exp %h got %h", s, e, g);
    end
  endtask
  task stop_test;
    $display("errors %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task av(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_read <= !w;
    avs_write <= w;
    avs_address <= a;
    avs_writedata <= d;
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      if (avs_waitrequest === 1'b0) break;
    end
    if (n == 20) begin
      err_total++;
      stop_test;
    end
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e, input string s);
    av(1'b0, a, 32'h0);
    chk(s, e, q);
  endtask
  task wal(input int lim);
    for (n = 0; n < lim; n++) begin
      @(negedge clk);
      if (alert_irq === 1'b1) break;
    end
  endtask
  task conv(input logic [31:0] cfg, input logic [27:0] lc, input int lim);
    @(posedge clk);
    light_code <= lc;
    av(1'b1, 8'h00, cfg);
    wal(lim);
  endtask
  // -----------------------------------------
  // scenarios
  // -----------------------------------------
  task t_rst;
    rd(8'h00, 32'hBC, "config");
    rd(8'h14, 32'h1, "mask");
    rd(8'h0C, 32'h0FFFFFFF, "thr_hi");
    av(1'b1, 8'h18, 32'hFFFF);
    rd(8'h18, 32'h0, "unmapped");
    chk("alert", 32'h0, alert_irq);
  endtask
  task t_bus;
    ctl.start;
    ctl.xfer(8'h22, 1'b1, b, r);
    chk("foreign_nack", 32'h1, r);
    ctl.stop;
    ctl.start;
    ctl.xfer(8'h88, 1'b1, b, r);
    chk("addr_ack", 32'h0, r);
    ctl.xfer(8'h08, 1'b1, b, r);
    ctl.xfer(8'h5A, 1'b1, b, r);
    ctl.stop;
    rd(8'h08, 32'h5A, "thr_lo");
    ctl.start;
    ctl.xfer(8'h88, 1'b1, b, r);
    ctl.xfer(8'h00, 1'b1, b, r);
    ctl.start;
    ctl.xfer(8'h89, 1'b1, b, r);
    ctl.xfer(8'hFF, 1'b1, b, r);
    chk("i2c_rd", 32'hBC, b);
    ctl.stop;
  endtask
  task t_tmo;
    ctl.start;
    ctl.xfer(8'h89, 1'b1, b, r);
    chk("tmo_ack", 32'h0, r);
    // target now pulls sda low for a zero data bit; the timeout must free it
    ctl.stall(300);
    ctl.stop;
    rd(8'h10, 32'h8, "tmo");
    av(1'b1, 8'h10, 32'hF);
  endtask
  task t_auto;
    conv(32'h20C, 28'h0123456, 700);
    chk("ct0", 32'h1, n > 590 && n < 615);
    av(1'b0, 8'h04, 32'h0);
    chk("exp", 32'h1, q[31:28]);
    chk("mant", 32'h91A2B, q[19:0]);
    rd(8'h00, 32'h00C, "mode_back");
    av(1'b1, 8'h10, 32'hF);
  endtask
  task t_man;
    conv(32'h208, 28'h0ABCDEF, 700);
    av(1'b0, 8'h04, 32'h0);
    chk("exp", 32'h8, q[31:28]);
    chk("mant", 32'h0ABCD, q[19:0]);
    av(1'b1, 8'h10, 32'hF);
  endtask
  task t_force;
    conv(32'h10C, 28'h100, 2000);
    chk("recovery", 32'h1, n > 1090 && n < 1120);
    av(1'b1, 8'h10, 32'hF);
  endtask
  task t_cont;
    conv(32'h30C, 28'h100, 700);
    chk("first", 32'h1, n < 700);
    av(1'b1, 8'h10, 32'hF);
    wal(700);
    chk("again", 32'h1, n < 700);
    av(1'b1, 8'h00, 32'h00C);
    av(1'b1, 8'h10, 32'hF);
    wal(1500);
    chk("off", 32'd1500, n);
  endtask
  task t_thr;
    av(1'b1, 8'h0C, 32'h100);
    av(1'b1, 8'h14, 32'h4);
    conv(32'h20C, 28'h1000, 700);
    chk("thr_alert", 32'h1, n < 700);
    rd(8'h10, 32'h5, "status");
    av(1'b1, 8'h10, 32'hF);
    @(negedge clk);
    chk("cleared", 32'h0, alert_irq);
  endtask

  initial begin
    arst_n = 1'b0;
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    light_code = 28'h0;
    err_total = 0;
    comparisons = 0;
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_rst;
    t_bus;
    t_tmo;
    t_auto;
    t_man;
    t_force;
    t_cont;
    t_thr;
    stop_test;
  end
endmodule // tb
